// file: bench/pacf_pin_model.sv
`timescale 1ns/100ps
// Drives the shared channel 7 pin with bursts of pulses
module pacf_pin_model (
  // Clock
  input  wire logic        clk_in,
  // Burst request: start, pulse count, cycles per level, idle level
  input  wire logic        go_in,
  input  wire logic [7:0]  num_in,
  input  wire logic [15:0] width_in,
  input  wire logic        idle_in,
  // Pin and status
  output logic             pin_out,
  output logic             busy_out
);
  logic [8:0]  half_q = 9'h000;
  logic [15:0] cnt_q  = 16'h0000;
  // Each level is held width_in cycles, never under one
  always_ff @(posedge clk_in) begin
    if (go_in) begin
      half_q <= {num_in, 1'b0};
      cnt_q  <= width_in;
    end else if (half_q != 9'h000) begin
      if (cnt_q > 16'h0001) begin
        cnt_q <= cnt_q - 16'h0001;
      end else begin
        pin_out <= ~pin_out;
        half_q  <= half_q - 9'h001;
        cnt_q   <= width_in;
      end
    end else begin
      pin_out <= idle_in;
    end
  end
  assign busy_out = (half_q != 9'h000);
endmodule : pacf_pin_model

// file: bench/tb.sv
`timescale 1ns/100ps
module tb;
  import pacf_pkg::*;
  logic             clk_in = 1'b0;
  logic             reset_n_in = 1'b0;
  logic             ptick = 1'b0;
  logic             go = 1'b0;
  logic             idle = 1'b0;
  logic [7:0]       num = 8'h00;
  logic [15:0]      wid = 16'h0004;
  logic             pin;
  logic             busy;
  logic             tick;
  logic [15:0]      cnt;
  logic             irq;
  pacf_axi_req_type req;
  pacf_axi_rsp_type rsp;
  logic [31:0]      d;
  logic [1:0]       last_resp;
  int               ticks = 0;
  int               t0;
  int               failures = 0;
  int               check_count = 0;

  // 20 MHz bus clock
  always #25 clk_in = ~clk_in;
  // Timer counter clock pulses seen so far
  always @(posedge clk_in) if (tick === 1'b1) ticks <= ticks + 1;

  pacf_top #(.GATE_DIV(PACF_GATE_DIV)) dut_u (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .axi_req_in(req),
    .axi_rsp_out(rsp), .channel7_pin_in(pin), .prescaler_tick_in(ptick),
    .timer_tick_out(tick), .accum_count_out(cnt), .irq_out(irq));
  pacf_pin_model pin_u (
    .clk_in(clk_in), .go_in(go), .num_in(num), .width_in(wid),
    .idle_in(idle), .pin_out(pin), .busy_out(busy));

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  // Bounded wait ran out: count it and stop
  task automatic hang();
    failures++;
    $display("MISMATCH timeout expected answer seen none");
    summarize();
  endtask : hang

  // One write; address and data offered together, bready held high
  task automatic wr(logic [7:0] a, logic [31:0] v);
    int n;
    logic aw;
    logic w;
    @(posedge clk_in);
    aw = 1'b1;
    w = 1'b1;
    req.awaddr <= a;
    req.wdata <= v;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_in);
      if (aw && rsp.awready) begin
        req.awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (w && rsp.wready) begin
        req.wvalid <= 1'b0;
        w = 1'b0;
      end
      if (rsp.bvalid === 1'b1) break;
    end
    if (n == 50) hang();
    req.bready <= 1'b0;
    chk("bresp", rsp.bresp, PACF_RESP_OKAY);
  endtask : wr

  task automatic rd(logic [7:0] a);
    int n;
    @(posedge clk_in);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_in);
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
      if (rsp.rvalid === 1'b1) break;
    end
    if (n == 50) hang();
    req.rready <= 1'b0;
    d = rsp.rdata;
    last_resp = rsp.rresp;
  endtask : rd

  // Burst of n pulses; four edges of sync and detect follow
  task automatic pulse(logic [7:0] n, logic [15:0] w);
    int k;
    @(posedge clk_in);
    num <= n;
    wid <= w;
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    @(posedge clk_in);
    for (k = 0; k < 2000 && busy; k++) @(posedge clk_in);
    if (k == 2000) hang();
    repeat (4) @(posedge clk_in);
  endtask : pulse

  task automatic set_idle(logic v);
    @(posedge clk_in);
    idle <= v;
    repeat (5) @(posedge clk_in);
  endtask : set_idle

  task automatic ptk(int n);
    repeat (n) begin
      @(posedge clk_in);
      ptick <= 1'b1;
      @(posedge clk_in);
      ptick <= 1'b0;
    end
    repeat (3) @(posedge clk_in);
  endtask : ptk

  // Interrupt output is registered, so let it settle first
  task automatic chk_irq(logic e);
    repeat (2) @(posedge clk_in);
    chk("irq", irq, e);
  endtask : chk_irq

  task automatic t_reset();
    rd(PACF_OFS_CONTROL); chk("ctl", d, {24'h0, PACF_CTL_RESET});
    rd(PACF_OFS_FLAGS);   chk("flg", d, {30'h0, PACF_FLG_RESET});
    rd(PACF_OFS_SYSCTL);  chk("sys", d, {24'h0, PACF_SYS_RESET});
    rd(PACF_OFS_COUNT);   chk("cnt", d, {16'h0, PACF_CNT_RESET});
    rd(8'h30);            chk("resp", last_resp, PACF_RESP_SLVERR);
    wr(PACF_OFS_COUNT, 32'h1234);
    rd(PACF_OFS_COUNT);   chk("cntw", d, 32'h1234);
    $display("test reset done");
  endtask : t_reset

  task automatic t_event();
    wr(PACF_OFS_CONTROL, 32'h30);
    pulse(8'h02, 16'h0004);
    rd(PACF_OFS_COUNT); chk("off", d, 32'h1234);
    wr(PACF_OFS_COUNT, 32'h0);
    wr(PACF_OFS_CONTROL, 32'h41);
    pulse(8'h03, 16'h0004);
    rd(PACF_OFS_COUNT); chk("fall", d, 32'h3);
    chk("cnto", {16'h0, cnt}, 32'h3);
    rd(PACF_OFS_FLAGS); chk("pif", d, 32'h1);
    chk_irq(1'b1);
    wr(PACF_OFS_CONTROL, 32'h50);
    chk_irq(1'b0);
    pulse(8'h02, 16'h0004);
    rd(PACF_OFS_COUNT); chk("rise", d, 32'h5);
    // Clear refused while both enables are off
    wr(PACF_OFS_CONTROL, 32'h10);
    wr(PACF_OFS_FLAGS, 32'h1);
    rd(PACF_OFS_FLAGS); chk("clr0", d, 32'h1);
    wr(PACF_OFS_CONTROL, 32'h40);
    wr(PACF_OFS_FLAGS, 32'h0);
    rd(PACF_OFS_FLAGS); chk("clrz", d, 32'h1);
    wr(PACF_OFS_FLAGS, 32'h1);
    rd(PACF_OFS_FLAGS); chk("clr1", d, 32'h0);
    $display("test event done");
  endtask : t_event

  task automatic t_ovf();
    wr(PACF_OFS_COUNT, 32'hffff);
    wr(PACF_OFS_CONTROL, 32'h42);
    chk_irq(1'b0);
    pulse(8'h01, 16'h0004);
    rd(PACF_OFS_COUNT); chk("wrap", d, 32'h0);
    chk("cntw0", {16'h0, cnt}, 32'h0);
    rd(PACF_OFS_FLAGS); chk("ovf", d, 32'h3);
    chk_irq(1'b1);
    wr(PACF_OFS_CONTROL, 32'h40);
    chk_irq(1'b0);
    wr(PACF_OFS_SYSCTL, 32'h10);
    rd(PACF_OFS_COUNT);
    rd(PACF_OFS_FLAGS); chk("ffc", d, 32'h0);
    wr(PACF_OFS_SYSCTL, 32'h0);
    $display("test overflow done");
  endtask : t_ovf

  // Gate of 266 cycles spans four or five divide-by-64 periods
  task automatic t_gated();
    wr(PACF_OFS_SYSCTL, 32'h80);
    wr(PACF_OFS_COUNT, 32'h0);
    wr(PACF_OFS_CONTROL, 32'h60);
    pulse(8'h01, 16'd266);
    rd(PACF_OFS_COUNT); chk("g0", d inside {4, 5}, 1);
    rd(PACF_OFS_FLAGS); chk("g0f", d, 32'h1);
    wr(PACF_OFS_FLAGS, 32'h1);
    set_idle(1'b1);
    // Close the gate before clearing, so no gated tick slips in
    wr(PACF_OFS_CONTROL, 32'h70);
    wr(PACF_OFS_COUNT, 32'h0);
    pulse(8'h01, 16'd266);
    rd(PACF_OFS_COUNT); chk("g1", d inside {4, 5}, 1);
    rd(PACF_OFS_FLAGS); chk("g1f", d, 32'h1);
    wr(PACF_OFS_SYSCTL, 32'h0);
    wr(PACF_OFS_COUNT, 32'h0);
    pulse(8'h01, 16'd266);
    rd(PACF_OFS_COUNT); chk("gten", d, 32'h0);
    wr(PACF_OFS_CONTROL, 32'h0);
    set_idle(1'b0);
    $display("test gated done");
  endtask : t_gated

  task automatic t_clk();
    wr(PACF_OFS_COUNT, 32'h0);
    wr(PACF_OFS_CONTROL, 32'h44);
    t0 = ticks;
    pulse(8'h03, 16'h0004);
    ptk(2);
    chk("acc", ticks - t0, 3);
    wr(PACF_OFS_CONTROL, 32'h04);
    t0 = ticks;
    ptk(5);
    chk("dis", ticks - t0, 5);
    wr(PACF_OFS_COUNT, 32'hfe);
    wr(PACF_OFS_CONTROL, 32'h48);
    t0 = ticks;
    pulse(8'h03, 16'h0004);
    chk("d256", ticks - t0, 1);
    wr(PACF_OFS_COUNT, 32'hffff);
    wr(PACF_OFS_CONTROL, 32'h4c);
    t0 = ticks;
    pulse(8'h02, 16'h0004);
    chk("d64k", ticks - t0, 1);
    $display("test clock select done");
  endtask : t_clk

  initial begin
    req = '0;
    repeat (16) @(posedge clk_in);
    reset_n_in <= 1'b1;
    t_reset();
    t_event();
    t_ovf();
    t_gated();
    t_clk();
    summarize();
  end
endmodule : tb

// file: hw/pacf_div.sv
`timescale 1ns/100ps
module pacf_div #(
  parameter int unsigned DIV = 64
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  // Divider runs only while the timer runs
  input  wire logic run_in,
  output logic      tick_out
);

  localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_q;

  // Elaboration check: a divider below two has no period to count
  if (DIV < 2) begin : g_bad_div
    $error("pacf_div: DIV must be at least 2");
  end

  // Held at zero while stopped, so no stray tick after restart
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || !run_in) begin
      cnt_q <= '0;
    end else if (cnt_q == LAST) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  // One bus clock per period, none while stopped
  assign tick_out = run_in && (cnt_q == LAST);

endmodule : pacf_div

// file: hw/pacf_pkg.sv
package pacf_pkg;

  // Register byte addresses
  localparam logic [7:0] PACF_OFS_CONTROL = 8'h20;
  localparam logic [7:0] PACF_OFS_FLAGS   = 8'h24;
  localparam logic [7:0] PACF_OFS_COUNT   = 8'h28;
  localparam logic [7:0] PACF_OFS_SYSCTL  = 8'h2c;

  // Control register fields
  localparam int unsigned PACF_CTL_ENABLE = 6;
  localparam int unsigned PACF_CTL_MODE   = 5;
  localparam int unsigned PACF_CTL_EDGE   = 4;
  localparam int unsigned PACF_CTL_CLK_HI = 3;
  localparam int unsigned PACF_CTL_CLK_LO = 2;
  localparam int unsigned PACF_CTL_OVF_IE = 1;
  localparam int unsigned PACF_CTL_IN_IE  = 0;
  localparam logic [7:0]  PACF_CTL_MASK   = 8'h7f;

  // Flag register fields
  localparam int unsigned PACF_FLG_OVF  = 1;
  localparam int unsigned PACF_FLG_IN   = 0;
  localparam logic [1:0]  PACF_FLG_ALL  = 2'h3;

  // Timer system control fields
  localparam int unsigned PACF_SYS_TEN  = 7;
  localparam int unsigned PACF_SYS_FFC  = 4;
  localparam logic [7:0]  PACF_SYS_MASK = 8'h90;

  // Reset values
  localparam logic [7:0]  PACF_CTL_RESET = 8'h00;
  localparam logic [1:0]  PACF_FLG_RESET = 2'h0;
  localparam logic [7:0]  PACF_SYS_RESET = 8'h00;
  localparam logic [15:0] PACF_CNT_RESET = 16'h0000;

  // Counting constants
  localparam int unsigned PACF_GATE_DIV  = 64;
  localparam logic [15:0] PACF_CNT_MAX   = 16'hffff;
  localparam logic [7:0]  PACF_LOW_MAX   = 8'hff;

  // Bus responses
  localparam logic [1:0]  PACF_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  PACF_RESP_SLVERR = 2'h2;

  // Timer counter clock sources
  typedef enum logic [1:0] {
    PACF_CLK_PRESCALER = 2'h0,
    PACF_CLK_ACCUM     = 2'h1,
    PACF_CLK_DIV256    = 2'h2,
    PACF_CLK_DIV65536  = 2'h3
  } pacf_clksel_type;

  // AXI4-Lite master to slave
  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } pacf_axi_req_type;

  // AXI4-Lite slave to master
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } pacf_axi_rsp_type;

  // Whole state of the accumulator top
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [1:0]  flags;
    logic [7:0]  sysctl;
    logic [15:0] count;
    logic        pin_prev;
    logic        tick;
    logic        irq;
    logic        aw_got;
    logic [7:0]  awaddr;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pacf_state_type;

endpackage : pacf_pkg

// file: hw/pacf_sync.sv
`timescale 1ns/100ps
module pacf_sync (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  // Asynchronous level in, synchronised level out
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_q;
  logic sync_q;

  // Two stages; only the second stage is ever looked at
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : pacf_sync

// file: hw/pacf_top.sv
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/100ps
module pacf_top
  import pacf_pkg::*;
#(
  parameter int unsigned GATE_DIV = PACF_GATE_DIV
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              reset_n_in,
  // Register bus
  input  wire pacf_axi_req_type  axi_req_in,
  output pacf_axi_rsp_type       axi_rsp_out,
  // Pin and timer prescaler
  input  wire logic              channel7_pin_in,
  input  wire logic              prescaler_tick_in,
  // Timer counter clock, count and interrupt
  output logic                   timer_tick_out,
  output logic [15:0]            accum_count_out,
  output logic                   irq_out
);

  // Elaboration check: the gate period is fixed, not tunable
  if (GATE_DIV != PACF_GATE_DIV) begin : g_bad_div
    $error("pacf_top: GATE_DIV must be 64");
  end

  pacf_state_type s_q;
  pacf_state_type s_d;
  logic           pin_sync;
  logic           div64_tick;
  logic           acc_en;
  logic           gated;
  logic           edge_sel;
  logic           timer_en;
  logic           rise;
  logic           fall;
  logic           sel_edge;
  logic           gate_on;
  logic           inc;
  logic           in_evt;
  logic           ovf_evt;
  logic           wr_fire;
  logic           rd_fire;
  logic           wr_count;
  logic           wr_flags;
  logic           cnt_access;
  logic           clr_allow;
  logic [1:0]     clr;
  logic           tick_sel;
  pacf_clksel_type clksel;

  // Pin shared with channel 7 capture, synchronised first
  pacf_sync u_pin_sync (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .async_in   (channel7_pin_in),
    .sync_out   (pin_sync)
  );

  // Gate clock derived from the timer's own run state
  pacf_div #(.DIV(GATE_DIV)) u_div64 (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .run_in     (timer_en),
    .tick_out   (div64_tick)
  );

  // Decoded control fields
  assign acc_en   = s_q.ctrl[PACF_CTL_ENABLE];
  assign gated    = acc_en && s_q.ctrl[PACF_CTL_MODE];
  assign edge_sel = s_q.ctrl[PACF_CTL_EDGE];
  assign timer_en = s_q.sysctl[PACF_SYS_TEN];
  assign clksel   = pacf_clksel_type'(
                      s_q.ctrl[PACF_CTL_CLK_HI:PACF_CTL_CLK_LO]);

  // Edge detect on the synchronised level only
  assign rise     = pin_sync && !s_q.pin_prev;
  assign fall     = !pin_sync && s_q.pin_prev;
  assign sel_edge = edge_sel ? rise : fall;
  // Edge 0 gates on high, edge 1 gates on low
  assign gate_on  = gated && (pin_sync ^ edge_sel);

  // Count events or gated ticks
  assign inc = acc_en && (s_q.ctrl[PACF_CTL_MODE]
                          ? (gate_on && div64_tick)
                          : sel_edge);
  // Same pin edge ends the gate or is the counted event
  assign in_evt  = acc_en && sel_edge;
  assign ovf_evt = inc && (s_q.count == PACF_CNT_MAX);

  // Bus decode
  assign wr_fire    = s_q.aw_got && s_q.w_got && !s_q.bvalid;
  assign rd_fire    = axi_req_in.arvalid && !s_q.rvalid;
  assign wr_count   = wr_fire && (s_q.awaddr == PACF_OFS_COUNT);
  assign wr_flags   = wr_fire && (s_q.awaddr == PACF_OFS_FLAGS);
  assign cnt_access = wr_count
                      || (rd_fire && axi_req_in.araddr == PACF_OFS_COUNT);
  assign clr_allow  = timer_en || acc_en;

  // Clear sources: write-one and fast clear on count access
  always_comb begin
    clr = '0;
    if (wr_flags && s_q.wstrb[0]) begin
      clr = s_q.wdata[1:0];
    end
    if (cnt_access && s_q.sysctl[PACF_SYS_FFC]) begin
      clr = PACF_FLG_ALL;
    end
    if (!clr_allow) begin
      clr = '0;
    end
  end

  // Timer counter clock; switches as soon as the field changes
  always_comb begin
    tick_sel = prescaler_tick_in;
    if (acc_en) begin
      unique case (clksel)
        PACF_CLK_PRESCALER: tick_sel = prescaler_tick_in;
        PACF_CLK_ACCUM:     tick_sel = inc;
        PACF_CLK_DIV256:    tick_sel = inc
                              && (s_q.count[7:0] == PACF_LOW_MAX);
        PACF_CLK_DIV65536:  tick_sel = ovf_evt;
      endcase
    end
  end

  // Next state of registers and bus slave
  always_comb begin
    s_d          = s_q;
    s_d.pin_prev = pin_sync;
    s_d.tick     = tick_sel;
    // Counter: a bus write beats a same-cycle increment
    s_d.count    = s_q.count + 16'(inc);
    if (wr_count) begin
      if (s_q.wstrb[0]) s_d.count[7:0]  = s_q.wdata[7:0];
      if (s_q.wstrb[1]) s_d.count[15:8] = s_q.wdata[15:8];
    end
    // Hardware set wins over any clear
    s_d.flags = (s_q.flags & ~clr) | {ovf_evt, in_evt};
    // Write address and data accepted in either order
    if (axi_req_in.awvalid && !s_q.aw_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = axi_req_in.awaddr;
    end
    if (axi_req_in.wvalid && !s_q.w_got && !s_q.bvalid) begin
      s_d.w_got = 1'b1;
      s_d.wdata = axi_req_in.wdata;
      s_d.wstrb = axi_req_in.wstrb;
    end
    if (wr_fire) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = PACF_RESP_OKAY;
      unique case (s_q.awaddr)
        PACF_OFS_CONTROL: if (s_q.wstrb[0])
                            s_d.ctrl = s_q.wdata[7:0] & PACF_CTL_MASK;
        PACF_OFS_SYSCTL:  if (s_q.wstrb[0])
                            s_d.sysctl = s_q.wdata[7:0] & PACF_SYS_MASK;
        PACF_OFS_FLAGS, PACF_OFS_COUNT: ;
        default:          s_d.bresp = PACF_RESP_SLVERR;
      endcase
    end
    if (s_q.bvalid && axi_req_in.bready) begin
      s_d.bvalid = 1'b0;
    end
    // Reads answer one cycle after the address is taken
    if (rd_fire) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = PACF_RESP_OKAY;
      s_d.rdata  = '0;
      unique case (axi_req_in.araddr)
        PACF_OFS_CONTROL: s_d.rdata[7:0]  = s_q.ctrl;
        PACF_OFS_FLAGS:   s_d.rdata[1:0]  = s_q.flags;
        PACF_OFS_COUNT:   s_d.rdata[15:0] = s_q.count;
        PACF_OFS_SYSCTL:  s_d.rdata[7:0]  = s_q.sysctl;
        default:          s_d.rresp       = PACF_RESP_SLVERR;
      endcase
    end else if (s_q.rvalid && axi_req_in.rready) begin
      s_d.rvalid = 1'b0;
    end
    // Level interrupt from unmasked sticky flags
    s_d.irq = (s_d.flags[PACF_FLG_OVF] && s_d.ctrl[PACF_CTL_OVF_IE])
           || (s_d.flags[PACF_FLG_IN] && s_d.ctrl[PACF_CTL_IN_IE]);
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      s_q        <= '0;
      s_q.ctrl   <= PACF_CTL_RESET;
      s_q.flags  <= PACF_FLG_RESET;
      s_q.sysctl <= PACF_SYS_RESET;
      s_q.count  <= PACF_CNT_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign axi_rsp_out.awready = !s_q.aw_got && !s_q.bvalid;
  assign axi_rsp_out.wready  = !s_q.w_got && !s_q.bvalid;
  assign axi_rsp_out.bvalid  = s_q.bvalid;
  assign axi_rsp_out.bresp   = s_q.bresp;
  assign axi_rsp_out.arready = !s_q.rvalid;
  assign axi_rsp_out.rvalid  = s_q.rvalid;
  assign axi_rsp_out.rdata   = s_q.rdata;
  assign axi_rsp_out.rresp   = s_q.rresp;
  assign timer_tick_out      = s_q.tick;
  assign accum_count_out     = s_q.count;
  assign irq_out             = s_q.irq;

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence gate_step_s;
    gated && gate_on && div64_tick && !wr_count;
  endsequence

  a_disabled_holds: assert property (
    (!acc_en && !wr_count) |=> $stable(s_q.count))
    else $error("count moved while accumulator disabled");

  a_event_counts: assert property (
    (acc_en && !gated && sel_edge && !wr_count)
      |=> s_q.count == $past(s_q.count) + 16'h0001)
    else $error("selected edge did not count");

  a_gate_counts: assert property (
    gate_step_s |=> s_q.count == $past(s_q.count) + 16'h0001)
    else $error("gated tick did not count");

  a_no_gate_clock: assert property (
    (gated && !timer_en && !wr_count) |=> $stable(s_q.count))
    else $error("gated count with timer stopped");

  a_overflow_flag: assert property (
    (ovf_evt && !wr_count)
      |=> s_q.flags[PACF_FLG_OVF] && s_q.count == 16'h0000)
    else $error("wrap did not set overflow flag");

  a_input_flag: assert property (
    in_evt |=> s_q.flags[PACF_FLG_IN])
    else $error("edge did not set input flag");

  a_clear_locked: assert property (
    (!acc_en && !timer_en) |=> ($past(s_q.flags) & ~s_q.flags) == 2'h0)
    else $error("flag cleared while both disabled");

  a_fast_clear: assert property (
    (cnt_access && s_q.sysctl[PACF_SYS_FFC] && clr_allow
      && !ovf_evt && !in_evt) |=> s_q.flags == 2'h0)
    else $error("fast clear left a flag set");

  a_prescaler_off: assert property (
    !acc_en |=> timer_tick_out == $past(prescaler_tick_in))
    else $error("timer clock not prescaler while disabled");

  a_div256_tick: assert property (
    (acc_en && clksel == PACF_CLK_DIV256 && inc
      && s_q.count[7:0] == 8'hff) |=> timer_tick_out)
    else $error("divide by 256 tick missing");

  a_ovf_irq: assert property (
    (s_q.flags[PACF_FLG_OVF] && s_q.ctrl[PACF_CTL_OVF_IE]) |-> irq_out)
    else $error("overflow interrupt not raised");

  a_irq_cause: assert property (
    irq_out |-> (s_q.flags[PACF_FLG_OVF] && s_q.ctrl[PACF_CTL_OVF_IE])
             || (s_q.flags[PACF_FLG_IN] && s_q.ctrl[PACF_CTL_IN_IE]))
    else $error("interrupt without enabled flag");

  // Pin path: a level held three samples reaches the edge detector
  sequence pin_rise_s;
    !channel7_pin_in ##1 channel7_pin_in [*3];
  endsequence

  sequence pin_fall_s;
    channel7_pin_in ##1 !channel7_pin_in [*3];
  endsequence

  a_pin_rise: assert property (pin_rise_s |-> rise)
    else $error("pin rise not seen by edge detector");

  a_pin_fall: assert property (pin_fall_s |-> fall)
    else $error("pin fall not seen by edge detector");

  // Gate closed: the count must sit still
  a_gate_shut_hi: assert property (
    (gated && !edge_sel && !pin_sync && !wr_count) |=> $stable(s_q.count))
    else $error("count moved with high gate closed");

  a_gate_shut_lo: assert property (
    (gated && edge_sel && pin_sync && !wr_count) |=> $stable(s_q.count))
    else $error("count moved with low gate closed");

  // Accumulator clock: one timer tick per count step, no more
  a_acc_tick: assert property (
    (acc_en && clksel == PACF_CLK_ACCUM && !wr_count)
      |=> timer_tick_out == (s_q.count != $past(s_q.count)))
    else $error("accumulator clock tick mismatch");

  a_presc_sel: assert property (
    (acc_en && clksel == PACF_CLK_PRESCALER)
      |=> timer_tick_out == $past(prescaler_tick_in))
    else $error("prescaler select not followed");

  // Flags rise only for their own cause
  a_ovf_cause: assert property (
    $rose(s_q.flags[PACF_FLG_OVF]) |-> $past(s_q.count) == 16'hffff)
    else $error("overflow flag set without wrap");

  a_in_cause: assert property (
    $rose(s_q.flags[PACF_FLG_IN])
      |-> $past(acc_en) && ($past(pin_sync) != $past(s_q.pin_prev)))
    else $error("input flag set without pin edge");

  // Write-one clears while either enable is on; zeros do nothing
  a_clear_takes: assert property (
    (wr_flags && s_q.wstrb[0] && s_q.wdata[PACF_FLG_IN]
      && (acc_en || timer_en) && !in_evt) |=> !s_q.flags[PACF_FLG_IN])
    else $error("write one did not clear input flag");

  a_zero_keeps: assert property (
    (wr_flags && s_q.wdata[1:0] == 2'h0 && !s_q.sysctl[PACF_SYS_FFC])
      |=> ($past(s_q.flags) & ~s_q.flags) == 2'h0)
    else $error("zero write cleared a flag");

  // Bus answers: write one cycle after both parts, read next cycle
  sequence rd_take_s;
    axi_req_in.arvalid && axi_rsp_out.arready;
  endsequence

  a_rd_answer: assert property (rd_take_s |=> axi_rsp_out.rvalid)
    else $error("read not answered");

  a_wr_answer: assert property (wr_fire |=> axi_rsp_out.bvalid)
    else $error("write not answered");

endmodule : pacf_top
